// ===== rtl/gis_pkg.sv
// Purpose: constants and types for the global interrupt status block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: bit positions follow the status word layout
package gis_pkg;
	localparam logic [11:0] GIS_STATUS_ADDR = 12'h004;
	localparam int          GIS_ADDR_W      = 12;
	localparam logic [31:0] GIS_STATUS_RST  = 32'h0000_0000;
	localparam int          GIS_RX_LSB      = 28;
	localparam int          GIS_TX_LSB      = 24;
	localparam int          GIS_CFG_BIT     = 21;
	localparam int          GIS_FAIL_BIT    = 1;
	localparam int          GIS_OK_BIT      = 0;
	localparam int          GIS_NCH         = 4;
	// implemented bits: 31:24, 21, 1, 0
	localparam logic [31:0] GIS_IMPL_MASK   = 32'hFF20_0003;
	localparam logic [1:0]  GIS_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  GIS_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0] rx_vec;
		logic [3:0] tx_vec;
		logic       cfg_vec;
		logic       ar_done;
		logic       ar_failed;
	} gis_event_s;

	typedef enum logic [1:0] {
		GIS_W_IDLE = 2'h0,
		GIS_W_RESP = 2'h1
	} gis_wstate_e;
endpackage

// ===== rtl/gis_global_interrupt_status.sv
// Purpose: global interrupt status register with write-one-to-clear flags
// Assumes: event pulses come from DMA logic on aclk, one cycle each
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module gis_global_interrupt_status (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// hardware events
	input  wire gis_pkg::gis_event_s   events,
	// axi4-lite write address
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// interrupt line, low while asserted
	output logic                       inta_n
);
	logic [31:0]         status;
	logic [31:0]         next_status;
	logic [31:0]         set_vec;
	logic [31:0]         clr_vec;
	logic                next_inta_n;
	logic                aw_held;
	logic                next_aw_held;
	logic [11:0]         aw_addr;
	logic [11:0]         next_aw_addr;
	logic                w_held;
	logic                next_w_held;
	logic [31:0]         w_data;
	logic [31:0]         next_w_data;
	logic [3:0]          w_strb;
	logic [3:0]          next_w_strb;
	gis_pkg::gis_wstate_e wstate;
	gis_pkg::gis_wstate_e next_wstate;
	logic [1:0]          next_bresp;
	logic                next_awready;
	logic                next_wready;
	logic                next_bvalid;
	logic                next_arready;
	logic                next_rvalid;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;
	logic                do_write;

	default clocking cb_main @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic hit(input logic [11:0] a);
		hit = (a[11:2] == gis_pkg::GIS_STATUS_ADDR[11:2]);
	endfunction

	// write channel: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_wstate  = wstate;
		next_bresp   = s_axi_bresp;
		next_bvalid  = s_axi_bvalid;
		do_write     = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		unique case (wstate)
			gis_pkg::GIS_W_IDLE: begin
				if (aw_held && w_held) begin
					do_write     = hit(aw_addr);
					next_bresp   = hit(aw_addr) ? gis_pkg::GIS_RESP_OKAY
						: gis_pkg::GIS_RESP_SLVERR;
					next_bvalid  = 1'b1;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
					next_wstate  = gis_pkg::GIS_W_RESP;
				end
			end
			gis_pkg::GIS_W_RESP: begin
				if (s_axi_bready) begin
					next_bvalid = 1'b0;
					next_wstate = gis_pkg::GIS_W_IDLE;
				end
			end
			default: next_wstate = gis_pkg::GIS_W_IDLE;
		endcase
		next_awready = !next_aw_held && (next_wstate == gis_pkg::GIS_W_IDLE);
		next_wready  = !next_w_held && (next_wstate == gis_pkg::GIS_W_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			aw_addr       <= 12'h000;
			w_held        <= 1'b0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			wstate        <= gis_pkg::GIS_W_IDLE;
			s_axi_bresp   <= gis_pkg::GIS_RESP_OKAY;
			s_axi_bvalid  <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			aw_held       <= next_aw_held;
			aw_addr       <= next_aw_addr;
			w_held        <= next_w_held;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			wstate        <= next_wstate;
			s_axi_bresp   <= next_bresp;
			s_axi_bvalid  <= next_bvalid;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
		end
	end

	// status flags
	always_comb begin
		set_vec = 32'h0000_0000;
		set_vec[gis_pkg::GIS_RX_LSB +: gis_pkg::GIS_NCH] = events.rx_vec;
		set_vec[gis_pkg::GIS_TX_LSB +: gis_pkg::GIS_NCH] = events.tx_vec;
		set_vec[gis_pkg::GIS_CFG_BIT]  = events.cfg_vec;
		set_vec[gis_pkg::GIS_FAIL_BIT] = events.ar_failed;
		set_vec[gis_pkg::GIS_OK_BIT]   = events.ar_done;
		clr_vec = do_write ? (w_data & strb_mask(w_strb)) : 32'h0000_0000;
		// set after clear so a same-cycle event survives
		next_status = ((status & ~clr_vec) | set_vec)
			& gis_pkg::GIS_IMPL_MASK;
		// only the last action request result is kept
		if (events.ar_done || events.ar_failed) begin
			next_status[gis_pkg::GIS_OK_BIT]   = events.ar_done;
			next_status[gis_pkg::GIS_FAIL_BIT] = events.ar_failed
				&& !events.ar_done;
		end
		next_inta_n = ~|next_status;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= gis_pkg::GIS_STATUS_RST;
			inta_n <= 1'b1;
		end else begin
			status <= next_status;
			inta_n <= next_inta_n;
		end
	end

	// read channel
	always_comb begin
		next_arready = s_axi_arready;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rdata   = hit(s_axi_araddr) ? status : 32'h0000_0000;
			next_rresp   = hit(s_axi_araddr) ? gis_pkg::GIS_RESP_OKAY
				: gis_pkg::GIS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end else if (!s_axi_rvalid) begin
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= gis_pkg::GIS_RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// flag register and interrupt line
	a_line_follows_flags: assert property (
		(status != 32'h0000_0000) |-> !inta_n)
		else $error("line idle with flag set");
	a_line_release: assert property (
		(status == 32'h0000_0000) && $past(aresetn) |-> inta_n)
		else $error("line held with no flags");
	a_line_on_event: assert property (
		(events.rx_vec != 4'h0) |=> !inta_n)
		else $error("line not raised by event");
	a_reserved_zero: assert property (
		(status & ~gis_pkg::GIS_IMPL_MASK) == 32'h0000_0000)
		else $error("reserved status bit set");
	a_rx_set_flag: assert property (
		events.rx_vec[3] |=> status[31])
		else $error("rx flag lost");
	a_rx_low_flag: assert property (
		events.rx_vec[0] |=> status[28])
		else $error("rx flag lost");
	a_tx_set_flag: assert property (
		events.tx_vec[0] |=> status[24])
		else $error("tx flag lost");
	a_tx_high_flag: assert property (
		events.tx_vec[3] |=> status[27])
		else $error("tx flag lost");
	a_cfg_set_flag: assert property (
		events.cfg_vec |=> status[21])
		else $error("cfg flag lost");
	a_cfg_no_spurious: assert property (
		!events.cfg_vec |=> !$rose(status[21]))
		else $error("cfg flag set without event");
	a_fail_result: assert property (
		events.ar_failed && !events.ar_done
		|=> status[1] && !status[0])
		else $error("fail result wrong");
	a_ok_result: assert property (
		events.ar_done |=> status[0] && !status[1])
		else $error("ok result wrong");
	a_result_single: assert property (
		!(status[1] && status[0]))
		else $error("both results shown");
	a_w1c_clear: assert property (
		do_write && w_strb[3] && w_data[31] && !events.rx_vec[3]
		|=> !status[31])
		else $error("w1c failed");
	a_zero_keeps: assert property (
		do_write && w_strb[3] && !w_data[30] && status[30]
		|=> status[30])
		else $error("zero write cleared bit");
	a_hold_no_write: assert property (
		!do_write && status[31] |=> status[31])
		else $error("flag cleared without a write");

	// register bus handshakes
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_holds: assert property (
		s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_write_answer: assert property (
		aw_held && w_held && (wstate == gis_pkg::GIS_W_IDLE)
		|=> s_axi_bvalid)
		else $error("write not answered");
	a_resp_holds: assert property (
		s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_busy_refuses: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_refuses: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");

	// main scenarios
	c_irq_raise: cover property ($fell(inta_n));
	c_irq_drop: cover property ($rose(inta_n));
	c_set_clear_race: cover property (do_write && |(clr_vec & set_vec));
	c_bad_addr: cover property (
		s_axi_bvalid && s_axi_bresp == gis_pkg::GIS_RESP_SLVERR);
	c_lane_write: cover property (do_write && (w_strb != 4'hF));
endmodule
`default_nettype wire

// ===== sim/gis_host_model.sv
// Purpose: host side AXI4-Lite master model for the status block
// Assumes: one write and one read at most under way, bounded waits
// Notes: tasks are called by hierarchical name from the bench
`timescale 1ns/100ps
`default_nettype none
module gis_host_model (
	// clock
	input  wire logic        aclk,
	// write channels
	output logic [11:0]      awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	// read channels
	output logic [11:0]      araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	int tmo = 0;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// ready is looked at mid-cycle, registered so it holds to the edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic pa, pw, ta, tw, got;
		int   i;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		pa = 1'b1;
		pw = 1'b1;
		got = 1'b0;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		for (i = 0; i < 40 && (pa || pw); i++) begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			@(posedge aclk);
			if (ta) pa = 1'b0;
			if (tw) pw = 1'b0;
			awvalid <= pa;
			wvalid  <= pw;
		end
		if (pa || pw) tmo++;
		bready <= 1'b1;
		for (i = 0; i < 40 && !got; i++) begin
			@(negedge aclk);
			got = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		if (!got) tmo++;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic pa, ta, got;
		int   i;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		pa = 1'b1;
		got = 1'b0;
		for (i = 0; i < 40 && !got; i++) begin
			@(negedge aclk);
			ta = arready;
			got = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) pa = 1'b0;
			arvalid <= pa;
		end
		rready <= 1'b0;
		if (!got) tmo++;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for the global interrupt status block
// Assumes: events are one-cycle pulses, status word at byte 0x004
// Notes: set-versus-clear lands one event on the clearing edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, inta_n;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	gis_pkg::gis_event_s events;
	int miscompares = 0;
	int n_checks = 0;
	gis_global_interrupt_status u_gis_global_interrupt_status (
		.aclk(aclk), .aresetn(aresetn), .events(events),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .inta_n(inta_n));
	gis_host_model u_gis_host_model (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic finish_test;
		miscompares += u_gis_host_model.tmo;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// event index order follows the packed struct, failed result at bit 0
	function automatic logic [31:0] exp_of(int i);
		if (i == 0) return 32'h0000_0002;
		if (i == 1) return 32'h0000_0001;
		if (i == 2) return 32'h0020_0000;
		return 32'h0000_0001 << (i + 21);
	endfunction
	task automatic pulse(input logic [10:0] e);
		@(posedge aclk);
		events <= e;
		@(posedge aclk);
		events <= '0;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic rd_chk(input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		u_gis_host_model.rd(gis_pkg::GIS_STATUS_ADDR, d, r);
		`CHK(d, e)
		`CHK(r, gis_pkg::GIS_RESP_OKAY)
	endtask
	task automatic wr_st(input logic [31:0] d);
		logic [1:0] r;
		u_gis_host_model.wr(gis_pkg::GIS_STATUS_ADDR, d, 4'hF, r);
		`CHK(r, gis_pkg::GIS_RESP_OKAY)
		@(negedge aclk);
	endtask
	task automatic t_each_flag;
		for (int i = 0; i < 11; i++) begin
			pulse(11'h001 << i);
			`CHK(inta_n, 1'b0)
			rd_chk(exp_of(i));
			wr_st(32'hFFFF_FFFF);
			rd_chk(32'h0);
			`CHK(inta_n, 1'b1)
		end
	endtask
	task automatic t_partial;
		pulse(11'h0C0);
		wr_st(32'h0000_0000);
		rd_chk(32'h1800_0000);
		wr_st(32'h1000_0000);
		rd_chk(32'h0800_0000);
		`CHK(inta_n, 1'b0)
		wr_st(32'h0800_0000);
		`CHK(inta_n, 1'b1)
	endtask
	task automatic t_last_result;
		pulse(11'h001);
		pulse(11'h002);
		rd_chk(32'h0000_0001);
		pulse(11'h001);
		rd_chk(32'h0000_0002);
		wr_st(32'hFFFF_FFFF);
	endtask
	task automatic t_set_wins;
		fork
			wr_st(32'hFFFF_FFFF);
			begin
				// clear applies one edge after the data is taken
				for (int i = 0; i < 40 && !(wvalid && wready); i++)
					@(posedge aclk);
				events <= 11'h004;
				@(posedge aclk);
				events <= '0;
			end
		join
		rd_chk(32'h0020_0000);
		wr_st(32'hFFFF_FFFF);
	endtask
	task automatic t_lanes;
		logic [1:0] r;
		pulse(11'h084);
		u_gis_host_model.wr(gis_pkg::GIS_STATUS_ADDR, 32'hFFFF_FFFF,
			4'h8, r);
		`CHK(r, gis_pkg::GIS_RESP_OKAY)
		@(negedge aclk);
		rd_chk(32'h0020_0000);
		`CHK(inta_n, 1'b0)
		wr_st(32'hFFFF_FFFF);
	endtask
	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		pulse(11'h080);
		u_gis_host_model.wr(12'h008, 32'hFFFF_FFFF, 4'hF, r);
		`CHK(r, gis_pkg::GIS_RESP_SLVERR)
		u_gis_host_model.rd(12'h008, d, r);
		`CHK(r, gis_pkg::GIS_RESP_SLVERR)
		`CHK(d, 32'h0)
		rd_chk(32'h1000_0000);
		wr_st(32'hFFFF_FFFF);
	endtask
	task automatic t_reset;
		pulse(11'h200);
		`CHK(inta_n, 1'b0)
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK(inta_n, 1'b1)
		rd_chk(gis_pkg::GIS_STATUS_RST);
	endtask
	initial begin
		aresetn = 1'b0;
		events = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK(inta_n, 1'b1)
		rd_chk(gis_pkg::GIS_STATUS_RST);
		t_each_flag();
		t_partial();
		t_last_result();
		t_set_wins();
		t_lanes();
		t_unmapped();
		t_reset();
		finish_test();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
